// ---- logic/alu_pkg.sv ----
// Purpose: shared types and constants for the rotate/subtract/xor/swap datapath
// Assumes: one core clock, decoder hands over one instruction per request
// Notes: summary of operation follows
// Summary of operation
// - rotate right moves the old carry into bit 7 and bit 0 into carry, no other flag moves.
// - on file-register forms, select 0 returns the result to the accumulator, 1 to the file.
// - literal minus accumulator goes to the accumulator, carry and low nibble flag mean no borrow.
// - file minus accumulator is routed by the select and sets carry, low nibble flag and zero.
// - literal xor accumulator goes to the accumulator and touches only the zero flag.
// - file xor accumulator is routed by the select and touches only the zero flag.
// - nibble exchange swaps the two halves of the file value, routed by select, no flag moves.
`default_nettype none
package alu_pkg;

  localparam int DATA_W = 8;
  localparam int NIB_W  = 4;
  localparam int ADDR_W = 7;

  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic              FLAG_RST   = 1'b0;
  localparam logic              DEST_ACC   = 1'b0;
  localparam logic              DEST_FILE  = 1'b1;

  typedef enum logic [2:0] {
    OP_ROTATE_RIGHT_THRU_BIT = 3'b000,
    OP_LITERAL_MINUS_ACC     = 3'b001,
    OP_FILE_MINUS_ACC        = 3'b010,
    OP_XOR_LITERAL_ACC       = 3'b011,
    OP_XOR_FILE_ACC          = 3'b100,
    OP_NIBBLE_EXCHANGE       = 3'b101
  } op_e;

  typedef struct packed {
    logic              valid;
    op_e               op;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] fileValue;
    logic [ADDR_W-1:0] fileAddr;
    logic              destSel;
  } req_s;

  typedef struct packed {
    logic carry;
    logic lowNibbleFlag;
    logic zero;
  } flags_s;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    flags_s            flags;
    logic              affectCarry;
    logic              affectLowNibble;
    logic              affectZero;
    logic              fileForm;
    logic              known;
  } calc_s;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wb_s;

endpackage : alu_pkg
`default_nettype wire

// ---- logic/alu_compute.sv ----
// Purpose: combinational result and flag generation for one instruction
// Assumes: operands already selected by the decoder
// Notes: subtraction uses the carry out of a + ~b + 1 as the no-borrow flag
`timescale 1ns/1ps
`default_nettype none
module alu_compute
  import alu_pkg::*;
(
  input  wire op_e               op,
  input  wire logic [DATA_W-1:0] literal,
  input  wire logic [DATA_W-1:0] fileValue,
  input  wire logic [DATA_W-1:0] acc,
  input  wire logic              carryIn,
  output calc_s                  calc
);

  logic [DATA_W-1:0] minuend;
  logic [DATA_W:0]   diffFull;
  logic [NIB_W:0]    diffLow;

  // literal form picks the immediate, file form the register value
  assign minuend  = (op == OP_LITERAL_MINUS_ACC) ? literal : fileValue;
  assign diffFull = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
  assign diffLow  = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~acc[NIB_W-1:0]} + 5'h01;

  always_comb begin
    calc                 = '0;
    calc.flags.carry     = carryIn;
    case (op)
      OP_ROTATE_RIGHT_THRU_BIT: begin
        calc.result      = {carryIn, fileValue[DATA_W-1:1]};
        calc.flags.carry = fileValue[0];
        calc.affectCarry = 1'b1;
        calc.fileForm    = 1'b1;
        calc.known       = 1'b1;
      end
      OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC: begin
        calc.result              = diffFull[DATA_W-1:0];
        calc.flags.carry         = diffFull[DATA_W];
        calc.flags.lowNibbleFlag = diffLow[NIB_W];
        calc.affectCarry         = 1'b1;
        calc.affectLowNibble     = 1'b1;
        calc.affectZero          = 1'b1;
        calc.fileForm            = (op == OP_FILE_MINUS_ACC);
        calc.known               = 1'b1;
      end
      OP_XOR_LITERAL_ACC: begin
        calc.result     = acc ^ literal;
        calc.affectZero = 1'b1;
        calc.known      = 1'b1;
      end
      OP_XOR_FILE_ACC: begin
        calc.result     = acc ^ fileValue;
        calc.affectZero = 1'b1;
        calc.fileForm   = 1'b1;
        calc.known      = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        calc.result   = {fileValue[NIB_W-1:0], fileValue[DATA_W-1:NIB_W]};
        calc.fileForm = 1'b1;
        calc.known    = 1'b1;
      end
      default: begin
        calc.known = 1'b0;
      end
    endcase
    calc.flags.zero = (calc.result == '0);
  end

endmodule : alu_compute
`default_nettype wire

// ---- logic/rotate_subtract_xor_swap_alu.sv ----
// Purpose: execute stage for rotate, subtract, xor and nibble exchange
// Assumes: register file applies the write-back before the next dependent read
// Notes: accumulator and status flags live here; results land one edge after the request
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_xor_swap_alu
  import alu_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire req_s              req,
  output logic [DATA_W-1:0]      accQ,
  output flags_s                 flagsQ,
  output logic [DATA_W-1:0]      resultQ,
  output wb_s                    wbQ,
  output logic                   doneQ,
  output logic                   illegalQ
);

  calc_s calc;
  logic  take;
  logic  toFile;

  alu_compute u_compute (
    .op        (req.op),
    .literal   (req.literal),
    .fileValue (req.fileValue),
    .acc       (accQ),
    .carryIn   (flagsQ.carry),
    .calc      (calc)
  );

  assign take   = req.valid && calc.known;
  // literal forms ignore the select bit, so a stray 1 cannot write the file
  assign toFile = calc.fileForm && (req.destSel == DEST_FILE);

  // accumulator update
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accQ <= ACC_RST;
    end else if (take && !toFile) begin
      accQ <= calc.result;
    end
  end

  // status flags, only the affected subset moves
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flagsQ <= '{carry: FLAG_RST, lowNibbleFlag: FLAG_RST, zero: FLAG_RST};
    end else if (take) begin
      if (calc.affectCarry) begin
        flagsQ.carry <= calc.flags.carry;
      end
      if (calc.affectLowNibble) begin
        flagsQ.lowNibbleFlag <= calc.flags.lowNibbleFlag;
      end
      if (calc.affectZero) begin
        flagsQ.zero <= calc.flags.zero;
      end
    end
  end

  // file write-back, a one-cycle strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wbQ <= '0;
    end else begin
      wbQ.we <= take && toFile;
      if (take) begin
        wbQ.addr <= req.fileAddr;
        wbQ.data <= calc.result;
      end
    end
  end

  // result and completion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resultQ  <= '0;
      doneQ    <= 1'b0;
      illegalQ <= 1'b0;
    end else begin
      doneQ    <= take;
      illegalQ <= req.valid && !calc.known;
      if (take) begin
        resultQ <= calc.result;
      end
    end
  end

  // checks
  property p_rotate;
    @(posedge clock) disable iff (rst)
    (req.valid && req.op == OP_ROTATE_RIGHT_THRU_BIT) |=>
      (resultQ == {$past(flagsQ.carry), $past(req.fileValue[DATA_W-1:1])})
      && (flagsQ.carry == $past(req.fileValue[0]))
      && $stable(flagsQ.zero) && $stable(flagsQ.lowNibbleFlag);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate result or flags wrong");

  property p_dest_acc;
    @(posedge clock) disable iff (rst)
    (take && calc.fileForm && req.destSel == DEST_ACC) |=>
      !wbQ.we && (accQ == resultQ);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("select 0 did not go to acc");

  property p_dest_file;
    @(posedge clock) disable iff (rst)
    (take && calc.fileForm && req.destSel == DEST_FILE) |=>
      wbQ.we && (wbQ.addr == $past(req.fileAddr)) && (wbQ.data == resultQ)
      && $stable(accQ) ##1 !wbQ.we || $past(req.valid);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("select 1 did not write file");

  property p_lit_sub;
    @(posedge clock) disable iff (rst)
    (req.valid && req.op == OP_LITERAL_MINUS_ACC) |=>
      (accQ == 8'($past(req.literal) - $past(accQ)))
      && (flagsQ.carry == ($past(accQ) <= $past(req.literal)))
      && (flagsQ.lowNibbleFlag == ($past(accQ[NIB_W-1:0]) <= $past(req.literal[NIB_W-1:0])))
      && !wbQ.we;
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

  property p_file_sub;
    @(posedge clock) disable iff (rst)
    (req.valid && req.op == OP_FILE_MINUS_ACC) |=>
      (resultQ == 8'($past(req.fileValue) - $past(accQ)))
      && (flagsQ.carry == ($past(accQ) <= $past(req.fileValue)))
      && (flagsQ.lowNibbleFlag == ($past(accQ[NIB_W-1:0]) <= $past(req.fileValue[NIB_W-1:0])))
      && (flagsQ.zero == ($past(req.fileValue) == $past(accQ)));
  endproperty
  a_file_sub: assert property (p_file_sub) else $error("file subtract wrong");

  property p_lit_xor;
    @(posedge clock) disable iff (rst)
    (req.valid && req.op == OP_XOR_LITERAL_ACC) |=>
      (accQ == ($past(accQ) ^ $past(req.literal)))
      && $stable(flagsQ.carry) && $stable(flagsQ.lowNibbleFlag) && !wbQ.we;
  endproperty
  a_lit_xor: assert property (p_lit_xor) else $error("literal xor wrong");

  property p_file_xor;
    @(posedge clock) disable iff (rst)
    (req.valid && req.op == OP_XOR_FILE_ACC) |=>
      (resultQ == ($past(accQ) ^ $past(req.fileValue)))
      && $stable(flagsQ.carry) && $stable(flagsQ.lowNibbleFlag);
  endproperty
  a_file_xor: assert property (p_file_xor) else $error("file xor wrong");

  property p_swap;
    @(posedge clock) disable iff (rst)
    (req.valid && req.op == OP_NIBBLE_EXCHANGE) |=>
      (resultQ == {$past(req.fileValue[NIB_W-1:0]), $past(req.fileValue[DATA_W-1:NIB_W])})
      && $stable(flagsQ);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");

  property p_zero;
    @(posedge clock) disable iff (rst)
    (take && calc.affectZero) |=> doneQ && (flagsQ.zero == (resultQ == '0));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag disagrees with result");

  property p_idle;
    @(posedge clock) disable iff (rst)
    !req.valid |=> !wbQ.we && !doneQ && $stable(accQ) && $stable(flagsQ);
  endproperty
  a_idle: assert property (p_idle) else $error("state moved without a request");

  // an unknown code must leave every architectural register alone
  property p_illegal;
    @(posedge clock) disable iff (rst)
    (req.valid && !calc.known) |=>
      illegalQ && !doneQ && !wbQ.we
      && $stable(accQ) && $stable(flagsQ) && $stable(resultQ);
  endproperty
  a_illegal: assert property (p_illegal) else $error("unknown op changed state");

  property p_legal_done;
    @(posedge clock) disable iff (rst)
    (req.valid && calc.known) |=> doneQ && !illegalQ;
  endproperty
  a_legal_done: assert property (p_legal_done) else $error("legal op did not complete");

  property p_lit_ignore_sel;
    @(posedge clock) disable iff (rst)
    (take && !calc.fileForm && req.destSel == DEST_FILE) |=>
      !wbQ.we && (accQ == resultQ);
  endproperty
  a_lit_ignore_sel: assert property (p_lit_ignore_sel) else $error("literal op wrote the file");

  property p_rotate_file;
    @(posedge clock) disable iff (rst)
    (take && req.op == OP_ROTATE_RIGHT_THRU_BIT && req.destSel == DEST_FILE) |=>
      wbQ.we && (wbQ.data == resultQ) && $stable(accQ)
      && (flagsQ.carry == $past(req.fileValue[0]));
  endproperty
  a_rotate_file: assert property (p_rotate_file) else $error("rotate to file wrong");

  // resultQ and the write-back word are levels that the decoder may read late
  property p_hold;
    @(posedge clock) disable iff (rst)
    !take |=> $stable(resultQ) && $stable(wbQ.addr) && $stable(wbQ.data);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without an accepted op");

  property p_file_sub_acc;
    @(posedge clock) disable iff (rst)
    (take && req.op == OP_FILE_MINUS_ACC && req.destSel == DEST_ACC) |=>
      !wbQ.we && (accQ == 8'($past(req.fileValue) - $past(accQ)));
  endproperty
  a_file_sub_acc: assert property (p_file_sub_acc) else $error("file subtract to acc wrong");

  property p_swap_file;
    @(posedge clock) disable iff (rst)
    (take && req.op == OP_NIBBLE_EXCHANGE && req.destSel == DEST_FILE) |=>
      wbQ.we && $stable(accQ)
      && (wbQ.data == {$past(req.fileValue[NIB_W-1:0]), $past(req.fileValue[DATA_W-1:NIB_W])});
  endproperty
  a_swap_file: assert property (p_swap_file) else $error("nibble exchange to file wrong");

endmodule : rotate_subtract_xor_swap_alu
`default_nettype wire

// ---- verif/file_model.sv ----
// Purpose: register file stand-in that applies the block's write-backs
// Assumes: write-back pulse lands on the rising edge after it shows
// Notes: bypass hands the next request the value written one cycle before
`timescale 1ns/1ps
`default_nettype none
module file_model
  import alu_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire wb_s               wb,
  input  wire logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0]      fileValue
);
  logic [DATA_W-1:0] mem [128];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) mem[i] <= DATA_W'(i * 29 + 6);
    end else if (wb.we) begin
      mem[wb.addr] <= wb.data;
    end
  end
  // without the bypass a back-to-back read would see stale contents
  assign fileValue = (wb.we && wb.addr == addr) ? wb.data : mem[addr];
endmodule : file_model
`default_nettype wire

// ---- verif/test_rotate_subtract_xor_swap_alu.sv ----
// Purpose: self-checking bench for the rotate/subtract/xor/swap datapath
// Assumes: inputs change on the falling edge, results show one edge later
// Notes: expected state kept in accE, flagsE and a mirror of the file
`timescale 1ns/1ps
`default_nettype none
module test_rotate_subtract_xor_swap_alu
  import alu_pkg::*;
;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  req_s              reqDrv = '0;
  req_s              req;
  logic [DATA_W-1:0] fileValue, accQ, resultQ, accE, mirror [128];
  flags_s            flagsQ, flagsE;
  wb_s               wbQ;
  logic              doneQ, illegalQ;
  int                bad_count = 0, total_checks = 0, cycles = 0;
  always #50 clock = ~clock;
  always_comb begin
    req = reqDrv;
    req.fileValue = fileValue;
  end
  rotate_subtract_xor_swap_alu i_dut (.clock(clock), .rst(rst), .req(req), .accQ(accQ),
    .flagsQ(flagsQ), .resultQ(resultQ), .wbQ(wbQ), .doneQ(doneQ), .illegalQ(illegalQ));
  file_model i_file (.clock(clock), .rst(rst), .wb(wbQ), .addr(reqDrv.fileAddr),
    .fileValue(fileValue));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // about 52 cycles are needed, so this only fires on a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic do_reset();
    rst = 1'b1;
    reqDrv = '0;
    repeat (4) @(negedge clock);
    chk("accRst", accQ, ACC_RST);
    chk("flagsRst", {5'h00, flagsQ}, 8'h00);
    chk("resRst", resultQ, 8'h00);
    rst = 1'b0;
    accE = ACC_RST;
    flagsE = '0;
    for (int i = 0; i < 128; i++) mirror[i] = 8'(i * 29 + 6);
    $display("test reset done");
  endtask : do_reset
  task automatic run(input op_e op, input logic [7:0] lit, input logic [6:0] addr,
                     input logic dest);
    logic [7:0] fv, res, opnd;
    flags_s     f;
    logic       toFile;
    fv = mirror[addr];
    f = flagsE;
    opnd = (op == OP_LITERAL_MINUS_ACC) ? lit : fv;
    toFile = dest && (op inside {OP_ROTATE_RIGHT_THRU_BIT, OP_FILE_MINUS_ACC,
                                 OP_XOR_FILE_ACC, OP_NIBBLE_EXCHANGE});
    case (op)
      OP_ROTATE_RIGHT_THRU_BIT: begin
        res = {flagsE.carry, fv[7:1]};
        f.carry = fv[0];
      end
      OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC: begin
        res = opnd - accE;
        f.carry = accE <= opnd;
        f.lowNibbleFlag = accE[3:0] <= opnd[3:0];
      end
      OP_XOR_LITERAL_ACC: res = accE ^ lit;
      OP_XOR_FILE_ACC: res = accE ^ fv;
      default: res = {fv[3:0], fv[7:4]};
    endcase
    if (op != OP_ROTATE_RIGHT_THRU_BIT && op != OP_NIBBLE_EXCHANGE) f.zero = res == 8'h00;
    reqDrv.valid = 1'b1;
    reqDrv.op = op;
    reqDrv.literal = lit;
    reqDrv.fileAddr = addr;
    reqDrv.destSel = dest;
    @(negedge clock);
    chk("done", {7'h00, doneQ}, 8'h01);
    chk("result", resultQ, res);
    chk("flags", {5'h00, flagsQ}, {5'h00, f});
    chk("wbWe", {7'h00, wbQ.we}, {7'h00, toFile});
    if (toFile) chk("wbData", wbQ.data, res);
    if (toFile) chk("wbAddr", {1'b0, wbQ.addr}, {1'b0, addr});
    if (toFile) mirror[addr] = res;
    else accE = res;
    chk("acc", accQ, accE);
    flagsE = f;
  endtask : run
  task automatic idle();
    reqDrv.valid = 1'b0;
    @(negedge clock);
    chk("doneLow", {7'h00, doneQ}, 8'h00);
    chk("weLow", {7'h00, wbQ.we}, 8'h00);
  endtask : idle
  task automatic t_rotate();
    run(OP_ROTATE_RIGHT_THRU_BIT, 8'h00, 7'h10, 1'b0);
    for (int k = 0; k < 4; k++) run(OP_ROTATE_RIGHT_THRU_BIT, 8'h00, 7'h11, k[0]);
    idle();
    $display("test rotate done");
  endtask : t_rotate
  task automatic t_sub();
    logic [7:0] accs [6] = '{8'h05, 8'h06, 8'h13, 8'h1f, 8'h00, 8'hff};
    logic [7:0] lits [6] = '{8'h05, 8'h05, 8'h24, 8'h20, 8'hff, 8'h00};
    for (int i = 0; i < 6; i++) begin
      run(OP_XOR_LITERAL_ACC, accE ^ accs[i], 7'h00, 1'b0);
      run(OP_LITERAL_MINUS_ACC, lits[i], 7'h00, i[0]);
    end
    // operand one below, equal to and above the file value
    for (int i = 0; i < 4; i++) begin
      run(OP_XOR_LITERAL_ACC, accE ^ (mirror[7'(i + 32)] + 8'(i) - 8'h01), 7'h00, 1'b0);
      run(OP_FILE_MINUS_ACC, 8'h00, 7'(i + 32), i[0]);
    end
    idle();
    $display("test subtract done");
  endtask : t_sub
  task automatic t_xor_swap();
    run(OP_XOR_FILE_ACC, 8'h00, 7'h30, 1'b0);
    run(OP_XOR_LITERAL_ACC, accE ^ mirror[7'h31], 7'h00, 1'b0);
    run(OP_XOR_FILE_ACC, 8'h00, 7'h31, 1'b1);
    run(OP_NIBBLE_EXCHANGE, 8'h00, 7'h40, 1'b0);
    run(OP_NIBBLE_EXCHANGE, 8'h00, 7'h40, 1'b1);
    run(OP_XOR_FILE_ACC, 8'h00, 7'h40, 1'b1);
    idle();
    $display("test xor swap done");
  endtask : t_xor_swap
  task automatic t_illegal();
    for (int k = 6; k < 8; k++) begin
      reqDrv.valid = 1'b1;
      reqDrv.op = op_e'(3'(k));
      @(negedge clock);
      chk("illegal", {7'h00, illegalQ}, 8'h01);
      chk("illDone", {7'h00, doneQ}, 8'h00);
      chk("illAcc", accQ, accE);
      chk("illFlags", {5'h00, flagsQ}, {5'h00, flagsE});
      idle();
    end
    $display("test illegal done");
  endtask : t_illegal
  initial begin
    do_reset();
    t_rotate();
    t_sub();
    t_xor_swap();
    t_illegal();
    do_reset();
    t_rotate();
    stop_test();
  end
endmodule : test_rotate_subtract_xor_swap_alu
`default_nettype wire
